// ==== rtl/mmst_pkg.sv ====
/*
  Constants for the module management sideband block: register map,
  field positions, reset values, state codes and timing counts.
  Assumes a single 40 MHz system clock drives every counter.
*/
// Behaviour
// - Finish management initialisation within 2000 ms.
// - Reset pulses of 10 us always reset.
// - Interrupt pin low within 200 ms.
// - Clearing read releases interrupt within 500 us.
// - Receive loss sets flag, interrupt, 100 ms.
// - Any flag sets bit and interrupt, 200 ms.
// - Mask set inhibits interrupt within 100 ms.
// - Mask clear restores interrupt within 100 ms.
// - Serial bus answers within 2 s.
// - Data ready: clear bit, raise interrupt, 2 s.
// - Fully functional 2 s after reset release.
// - Init limit holds with low power low.
// - Low power pin high: class 1, 100 ms.
// - Low power pin low: full function, 300 ms.
// - Low power/transmit disable switch within 100 ms.
// - Interrupt/receive loss switch within 100 ms.
// - Power override or set: class 1, 100 ms.
// - Override or set cleared: full function, 300 ms.
package mmst_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 40;    // System clock rate in MHz.
  localparam int unsigned RESET_MIN_US     = 10;    // Shortest qualified reset pulse.
  localparam int unsigned INIT_MAX_MS      = 2000;  // Longest allowed initialisation.
  localparam int unsigned INIT_TIME_US     = 1000;  // Initialisation time actually used.
  localparam int unsigned WAKE_TIME_US     = 100;   // Settle time when leaving low power.
  localparam int unsigned WAKE_MAX_MS      = 300;   // Longest allowed wake-up.
  // Reset pulse qualification, converted exactly to whole cycles.
  localparam int unsigned RESET_MIN_CYCLES = RESET_MIN_US * CLK_MHZ;
  // Initialisation time in cycles, and the ceiling it must stay below.
  localparam int unsigned INIT_CYCLES      = INIT_TIME_US * CLK_MHZ;
  localparam longint unsigned INIT_MAX_CYCLES = longint'(INIT_MAX_MS) * 1000 * CLK_MHZ;
  // Wake settle time in cycles, and its ceiling.
  localparam int unsigned WAKE_CYCLES      = WAKE_TIME_US * CLK_MHZ;
  localparam int unsigned WAKE_MAX_CYCLES  = WAKE_MAX_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam logic [3:0] REG_STATUS  = 4'h0;  // Read only state.
  localparam logic [3:0] REG_FLAGS   = 4'h1;  // Latched flags, clear on read.
  localparam logic [3:0] REG_MASK    = 4'h2;  // Interrupt mask per flag.
  localparam logic [3:0] REG_CONTROL = 4'h3;  // Power and pin function control.

  // Flag bit positions, shared by the flag and mask registers.
  localparam int unsigned NUM_FLAGS     = 4;
  localparam int unsigned FLAG_RX_LOSS  = 0;
  localparam int unsigned FLAG_TX_FAULT = 1;
  localparam int unsigned FLAG_DATA_RDY = 2;
  localparam int unsigned FLAG_AUX      = 3;

  // Status bit positions.
  localparam int unsigned ST_DATA_NOT_READY = 0;
  localparam int unsigned ST_INIT_BUSY      = 1;
  localparam int unsigned ST_LOW_POWER      = 2;
  localparam int unsigned ST_FULL_FUNCTION  = 3;
  localparam int unsigned ST_INT_PIN_LEVEL  = 4;

  // Control bit positions.
  localparam int unsigned CTL_POWER_OVERRIDE = 0;
  localparam int unsigned CTL_POWER_SET      = 1;
  localparam int unsigned CTL_LP_IS_TRANSMIT_DISABLE    = 2;
  localparam int unsigned CTL_INT_IS_LOS     = 3;

  // Reset values.
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Initialisation states, Gray coded along hold, init, run.
  typedef enum logic [1:0] {
    MMST_HOLD = 2'b00,
    MMST_INIT = 2'b01,
    MMST_RUN  = 2'b11
  } mmst_state_t;

endpackage

// ==== rtl/mmst_timer.sv ====
/*
  Elapsed time counter: counts clock cycles while run is high and
  flags done once CYCLES cycles have passed. Assumes run is synchronous.
*/
`timescale 1ns/1ps
module mmst_timer #(
  parameter int unsigned CYCLES = 400
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      done
);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  localparam int unsigned W = $clog2(CYCLES + 1);

  logic [W-1:0] count;  // Cycles elapsed since run rose.

  initial begin
    if (CYCLES < 1) begin
      $error("mmst_timer needs at least one cycle");
    end
  end

  // Count while running; dropping run restarts the measurement.
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!done) begin
      count <= count + 1'b1;
      done  <= (count == W'(CYCLES - 1));
    end
  end

endmodule

// ==== rtl/mmst_sticky.sv ====
/*
  One latched flag bit: set by an event, cleared by a clear request.
  Assumes both requests are synchronous one-cycle terms.
*/
`timescale 1ns/1ps
module mmst_sticky (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic clear,
  output logic      q
);

  // ---------------------------------------------------------------
  // Flag storage
  // ---------------------------------------------------------------
  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= 1'b0;
    end else begin
      q <= set | (q & ~clear);
    end
  end

endmodule

// ==== rtl/mmst_core.sv ====
/*
  Management sideband of a pluggable cable module: reset qualification,
  initialisation sequence, latched flags with mask and interrupt pin,
  dual function pins and power control.
  Assumes every input is synchronous to sys_clk and that the register
  port master follows the one-cycle strobe protocol.
*/
`timescale 1ns/1ps
module mmst_core #(
  parameter int unsigned INIT_CYCLES = mmst_pkg::INIT_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       module_reset_n,
  input  wire logic       low_power_select,
  input  wire logic       rx_loss,
  input  wire logic       tx_fault,
  input  wire logic       aux_flag,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       interrupt_pin_in,
  output logic            interrupt_pin_out,
  output logic            interrupt_pin_oe_n,
  output logic            management_init_state,
  output logic            bus_ready,
  output logic            low_power_mode,
  output logic            transmit_disable,
  output logic            full_function
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The chosen initialisation time must fit under the 2000 ms ceiling.
  initial begin
    if (INIT_CYCLES < 1 || longint'(INIT_CYCLES) >= mmst_pkg::INIT_MAX_CYCLES) begin
      $error("INIT_CYCLES outside the allowed initialisation window");
    end
    if (mmst_pkg::WAKE_CYCLES >= mmst_pkg::WAKE_MAX_CYCLES) begin
      $error("Wake settle time exceeds its ceiling");
    end
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  mmst_pkg::mmst_state_t state;       // Initialisation state.
  mmst_pkg::mmst_state_t next_state;  // Next initialisation state.

  logic       reset_n_prev;      // Module reset pin one cycle ago.
  logic       reset_qualified;   // Pin has been low long enough.
  logic       reset_armed;       // A qualified pulse awaits release.
  logic       reset_release;     // Rising edge after a qualified pulse.
  logic       init_done;         // Initialisation time elapsed.
  logic       wake_done;         // Wake settle time elapsed.
  logic       data_not_ready;    // Monitor data not yet valid.
  logic [7:0] mask;              // Interrupt mask per flag.
  logic [7:0] control;           // Power and pin function control.
  logic       rx_loss_prev;      // Receive loss one cycle ago.
  logic       tx_fault_prev;     // Transmit fault one cycle ago.
  logic       aux_prev;          // Auxiliary flag one cycle ago.

  logic [mmst_pkg::NUM_FLAGS-1:0] flags;       // Latched flags.
  logic [mmst_pkg::NUM_FLAGS-1:0] flag_set;    // Flag events this cycle.
  logic [mmst_pkg::NUM_FLAGS-1:0] flag_clear;  // Flag clears this cycle.

  // ---------------------------------------------------------------
  // Reset pulse qualification
  // ---------------------------------------------------------------
  // pulse width check
  // Only a low pulse of the minimum width restarts the module;
  // shorter glitches are ignored.
  mmst_timer #(
    .CYCLES (mmst_pkg::RESET_MIN_CYCLES)
  ) u_reset_width (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (~module_reset_n),
    .done    (reset_qualified)
  );

  // Release edge of a qualified pulse; it only clears reset_armed, init starts from the hold state on the pin level.
  assign reset_release = reset_armed & module_reset_n & ~reset_n_prev;

  // Remember the pin and whether a qualified pulse is pending.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reset_n_prev <= 1'b1;
      reset_armed  <= 1'b0;
    end else begin
      reset_n_prev <= module_reset_n;
      reset_armed  <= (reset_armed | reset_qualified) & ~reset_release;
    end
  end

  // ---------------------------------------------------------------
  // Initialisation sequence
  // ---------------------------------------------------------------
  // counter based timing
  // bounded initialisation time
  // The timer runs only while in the init state.
  mmst_timer #(
    .CYCLES (INIT_CYCLES)
  ) u_init_time (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (state == mmst_pkg::MMST_INIT),
    .done    (init_done)
  );

  // Next state: a qualified reset holds, release starts init again.
  always_comb begin
    next_state = state;
    case (state)
      mmst_pkg::MMST_HOLD: begin
        // Wait for the pin to be released.
        if (module_reset_n) begin
          next_state = mmst_pkg::MMST_INIT;
        end
      end
      mmst_pkg::MMST_INIT: begin
        if (reset_qualified) begin
          next_state = mmst_pkg::MMST_HOLD;
        end else if (init_done) begin
          next_state = mmst_pkg::MMST_RUN;
        end
      end
      mmst_pkg::MMST_RUN: begin
        if (reset_qualified) begin
          next_state = mmst_pkg::MMST_HOLD;
        end
      end
      default: begin
        next_state = mmst_pkg::MMST_HOLD;
      end
    endcase
  end

  // State register; power-on reset enters the hold state.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= mmst_pkg::MMST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Init state indicator and serial bus readiness.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      management_init_state <= 1'b1;
      bus_ready             <= 1'b0;
    end else begin
      management_init_state <= (next_state != mmst_pkg::MMST_RUN);
      bus_ready             <= (next_state == mmst_pkg::MMST_RUN);
    end
  end

  // data ready clears bit
  // Monitor data become valid when initialisation completes.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_not_ready <= 1'b1;
    end else if (next_state != mmst_pkg::MMST_RUN) begin
      data_not_ready <= 1'b1;
    end else begin
      data_not_ready <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  // Accesses are ignored until the serial bus is ready.
  wire wr_ok      = reg_write & bus_ready;
  wire rd_ok      = reg_read & bus_ready;
  wire wr_mask    = wr_ok & (reg_addr == mmst_pkg::REG_MASK);
  wire wr_control = wr_ok & (reg_addr == mmst_pkg::REG_CONTROL);
  wire wr_flags   = wr_ok & (reg_addr == mmst_pkg::REG_FLAGS);
  wire rd_flags   = rd_ok & (reg_addr == mmst_pkg::REG_FLAGS);

  // Status word showing the block's own state.
  wire [7:0] status_word = {
    3'h0,
    interrupt_pin_in,
    full_function,
    low_power_mode,
    (state != mmst_pkg::MMST_RUN),
    data_not_ready
  };

  // Read selection; unmapped addresses read as zero.
  wire [7:0] read_mux =
    (reg_addr == mmst_pkg::REG_STATUS)  ? status_word :
    (reg_addr == mmst_pkg::REG_FLAGS)   ? {4'h0, flags} :
    (reg_addr == mmst_pkg::REG_MASK)    ? mask :
    (reg_addr == mmst_pkg::REG_CONTROL) ? control : 8'h00;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (rd_ok) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Mask and control registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask    <= mmst_pkg::MASK_RESET;
      control <= mmst_pkg::CONTROL_RESET;
    end else begin
      if (wr_mask) begin
        mask <= reg_wdata;
      end
      if (wr_control) begin
        control <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag events
  // ---------------------------------------------------------------
  // Remember inputs so each condition latches on its onset.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_loss_prev  <= 1'b0;
      tx_fault_prev <= 1'b0;
      aux_prev      <= 1'b0;
    end else begin
      rx_loss_prev  <= rx_loss;
      tx_fault_prev <= tx_fault;
      aux_prev      <= aux_flag;
    end
  end

  assign flag_set[mmst_pkg::FLAG_RX_LOSS]  = rx_loss & ~rx_loss_prev;
  assign flag_set[mmst_pkg::FLAG_TX_FAULT] = tx_fault & ~tx_fault_prev;
  assign flag_set[mmst_pkg::FLAG_AUX]      = aux_flag & ~aux_prev;
  assign flag_set[mmst_pkg::FLAG_DATA_RDY] = init_done & (state == mmst_pkg::MMST_INIT);

  // clear on read
  // A read clears exactly the bits it returned; a write of one also clears.
  assign flag_clear = (rd_flags ? flags : '0)
                    | (wr_flags ? reg_wdata[mmst_pkg::NUM_FLAGS-1:0] : '0);

  // One latched bit per flag.
  for (genvar i = 0; i < mmst_pkg::NUM_FLAGS; i++) begin : g_flag
    mmst_sticky u_flag (
      .sys_clk (sys_clk),
      .reset   (reset),
      .set     (flag_set[i]),
      .clear   (flag_clear[i]),
      .q       (flags[i])
    );
  end

  // ---------------------------------------------------------------
  // Interrupt pin
  // ---------------------------------------------------------------
  // unmasked flag pulls low
  wire int_request = |(flags & ~mask[mmst_pkg::NUM_FLAGS-1:0]);

  // pin function select
  // In receive-loss mode the pin follows the loss condition directly.
  wire int_pin_low = control[mmst_pkg::CTL_INT_IS_LOS] ? rx_loss : int_request;

  // Open drain: the pin only ever drives low, enable active low.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interrupt_pin_out  <= 1'b0;
      interrupt_pin_oe_n <= 1'b1;
    end else begin
      interrupt_pin_out  <= 1'b0;
      interrupt_pin_oe_n <= ~int_pin_low;
    end
  end

  // ---------------------------------------------------------------
  // Power and dual function input
  // ---------------------------------------------------------------
  // input function select
  wire lp_pin_is_transmit_disable = control[mmst_pkg::CTL_LP_IS_TRANSMIT_DISABLE];

  wire low_power_req = (~lp_pin_is_transmit_disable & low_power_select)
                     | control[mmst_pkg::CTL_POWER_OVERRIDE]
                     | control[mmst_pkg::CTL_POWER_SET];

  mmst_timer #(
    .CYCLES (mmst_pkg::WAKE_CYCLES)
  ) u_wake_time (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (~low_power_req & (state == mmst_pkg::MMST_RUN)),
    .done    (wake_done)
  );

  // Power state, transmit disable and full function outputs.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      low_power_mode   <= 1'b0;
      transmit_disable <= 1'b0;
      full_function    <= 1'b0;
    end else begin
      low_power_mode   <= low_power_req;
      transmit_disable <= lp_pin_is_transmit_disable & low_power_select;
      full_function    <= wake_done & ~low_power_req;
    end
  end

endmodule

// ==== tb/mmst_host_model.sv ====
/*
  Host side of the sideband: reset pin, low-power pin, pulled-up wire.
  Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module mmst_host_model (
  input  wire logic sys_clk,
  input  wire logic interrupt_pin_out,
  input  wire logic interrupt_pin_oe_n,
  output logic      interrupt_pin_in,
  output logic      module_reset_n,
  output logic      low_power_select
);
  assign interrupt_pin_in = interrupt_pin_oe_n ? 1'b1 : interrupt_pin_out;

  // Pins idle released at time zero.
  initial begin
    module_reset_n = 1'b1;
    low_power_select = 1'b0;
  end

  task automatic pulse_reset(input int cycles);
    @(posedge sys_clk);
    module_reset_n <= 1'b0;
    repeat (cycles) @(posedge sys_clk);
    module_reset_n <= 1'b1;
  endtask

  task automatic set_low_power(input logic v);
    @(posedge sys_clk);
    low_power_select <= v;
  endtask
endmodule

// ==== tb/mmst_core_props.sv ====
/*
  Checker of the sideband timing relations of mmst_core.
  Assumes it sees only the ports of mmst_core, bound below.
*/
`timescale 1ns/1ps
module mmst_core_props #(
  parameter int unsigned INIT_CYCLES = mmst_pkg::INIT_CYCLES
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       module_reset_n,
  input wire logic       low_power_select,
  input wire logic       rx_loss,
  input wire logic       tx_fault,
  input wire logic       aux_flag,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       interrupt_pin_in,
  input wire logic       interrupt_pin_out,
  input wire logic       interrupt_pin_oe_n,
  input wire logic       management_init_state,
  input wire logic       bus_ready,
  input wire logic       low_power_mode,
  input wire logic       transmit_disable,
  input wire logic       full_function
);
  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  logic [3:0]  mask_sh;  // Mask as last written.
  logic [3:0]  ctl_sh;   // Control as last written.
  logic [2:0]  cond_d;   // Conditions one cycle ago.
  int unsigned init_cnt; // Cycles spent initialising.
  int unsigned rst_cnt;  // Cycles the reset pin has been low.
  int unsigned wake_cnt; // Cycles awake in run state.
  wire [2:0] cond   = {aux_flag, tx_fault, rx_loss};
  wire       wr_ok  = reg_write && bus_ready;
  wire       rise   = |(cond & ~cond_d);
  wire       unm    = |(cond & ~cond_d & ~{mask_sh[3], mask_sh[1:0]});
  wire       lp_req = (low_power_select && !ctl_sh[2]) || ctl_sh[1] || ctl_sh[0];

  // Tracks writes and counts spans that the assertions bound.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask_sh <= 4'h0;
      ctl_sh <= 4'h0;
      cond_d <= 3'h0;
      init_cnt <= 0;
      rst_cnt <= 0;
      wake_cnt <= 0;
    end else begin
      if (wr_ok && reg_addr == mmst_pkg::REG_MASK) mask_sh <= reg_wdata[3:0];
      if (wr_ok && reg_addr == mmst_pkg::REG_CONTROL) ctl_sh <= reg_wdata[3:0];
      cond_d <= cond;
      init_cnt <= (management_init_state && module_reset_n) ? init_cnt + 1 : 0;
      rst_cnt <= module_reset_n ? 0 : rst_cnt + 1;
      wake_cnt <= (bus_ready && !low_power_mode) ? wake_cnt + 1 : 0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_INIT_BOUND: assert property (init_cnt <= INIT_CYCLES + 3)
    else $error("initialisation too long");
  AST_READY_TIE: assert property (bus_ready == !management_init_state)
    else $error("bus ready disagrees with init state");
  AST_RESET_QUAL: assert property (rst_cnt >= mmst_pkg::RESET_MIN_CYCLES + 3
    |-> management_init_state) else $error("long reset pulse ignored");
  AST_FLAG_INT: assert property (bus_ready && unm && !ctl_sh[3]
    |-> ##[1:2] !interrupt_pin_oe_n) else $error("flag did not pull pin");
  AST_CLEAR_REL: assert property (reg_read && bus_ready
    && reg_addr == mmst_pkg::REG_FLAGS && !ctl_sh[3] && !rise
    |-> ##2 interrupt_pin_oe_n) else $error("pin not released");
  AST_MASK_SET: assert property (wr_ok && reg_addr == mmst_pkg::REG_MASK
    && reg_wdata[3:0] == 4'hf && !ctl_sh[3] |-> ##2 interrupt_pin_oe_n)
    else $error("mask did not hold pin");
  AST_DATA_RDY: assert property ($fell(management_init_state)
    && !mask_sh[2] && !ctl_sh[3] |-> ##[0:3] !interrupt_pin_oe_n)
    else $error("data ready did not pull pin");
  AST_LOW_POWER: assert property (bus_ready && $past(bus_ready)
    |-> low_power_mode == $past(lp_req)) else $error("low power wrong");
  AST_FULL_LATE: assert property (wake_cnt >= mmst_pkg::WAKE_CYCLES + 4
    |-> full_function) else $error("full function late");
  AST_TRANSMIT_DISABLE: assert property ((ctl_sh[2] && bus_ready && low_power_select)[*3]
    |-> transmit_disable) else $error("transmit disable not driven");
  AST_LOS: assert property ((ctl_sh[3] && bus_ready && rx_loss)[*3]
    |-> !interrupt_pin_oe_n) else $error("loss mode pin not low");

  COV_MASK: cover property (wr_ok && reg_addr == mmst_pkg::REG_MASK);
  COV_INT: cover property ($fell(interrupt_pin_oe_n));
  COV_FULL: cover property ($rose(full_function));
endmodule

bind mmst_core mmst_core_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (.*);

// ==== tb/mmst_core_tb.sv ====
/*
  Self-checking bench for mmst_core with the host model.
  Assumes the package, design, model and checker are compiled first.
*/
`timescale 1ns/1ps
module mmst_core_tb;
  localparam int INIT = 20;
  localparam int WAKE = mmst_pkg::WAKE_CYCLES;
  logic       sys_clk, reset, reg_write, reg_read, rd_pend;
  logic       interrupt_pin_in, interrupt_pin_out, interrupt_pin_oe_n;
  logic       management_init_state, bus_ready, low_power_mode;
  logic       transmit_disable, full_function, module_reset_n, low_power_select;
  logic [2:0] cond;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rnd;
  logic [7:0] exp_q[$], msk_q[$];
  logic [7:0] fbit[3] = '{8'h01, 8'h02, 8'h08};
  int         fails, compares, n;

  mmst_core #(.INIT_CYCLES(INIT)) DUT (.*, .rx_loss(cond[0]), .tx_fault(cond[1]),
    .aux_flag(cond[2]));
  mmst_host_model host (.sys_clk(sys_clk), .interrupt_pin_out(interrupt_pin_out),
    .interrupt_pin_oe_n(interrupt_pin_oe_n), .interrupt_pin_in(interrupt_pin_in),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select));

  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    compares++;
    if (seen !== expd) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask

  // One register port cycle, launched just after a rising edge.
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  // Notes the expected read data, then issues the read.
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  // Idles the port for k edges and stops where outputs are settled.
  task automatic tick(input int k);
    repeat (k) bus(1'b0, 1'b0, 4'h0, 8'h00);
    @(negedge sys_clk);
  endtask

  // Waits, bounded, for bus_ready (0) or full_function (1) to reach v.
  task automatic wait_for(input int sel, input logic v, input int lim);
    n = 0;
    while (n < lim && (sel == 0 ? bus_ready : full_function) !== v) begin
      tick(1);
      n++;
    end
  endtask

  // Takes the oldest noted read result when read data stand.
  always @(posedge sys_clk) rd_pend <= reg_read;
  always @(negedge sys_clk) begin
    if (rd_pend === 1'b1) begin
      check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    results();
  end

  initial begin
    reset = 1'b1;
    cond = 3'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    fails = 0;
    compares = 0;
    rnd = 8'($urandom(38237));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    wait_for(0, 1'b1, INIT + 4);
    check(8'(management_init_state), 8'h00);
    tick(2);
    check(8'(interrupt_pin_oe_n), 8'h00);
    rd(mmst_pkg::REG_STATUS, 8'h00, 8'h13);
    rd(mmst_pkg::REG_FLAGS, 8'h04, 8'hff);
    rd(mmst_pkg::REG_MASK, 8'h00, 8'hff);
    wr(4'hf, rnd);
    rd(4'hf, 8'h00, 8'hff);
    rd(mmst_pkg::REG_CONTROL, 8'h00, 8'hff);
    tick(2);
    check(8'(interrupt_pin_oe_n), 8'h01);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      cond[i] <= 1'b1;
      tick(2);
      check(8'(interrupt_pin_oe_n), 8'h00);
      rd(mmst_pkg::REG_FLAGS, fbit[i], 8'hff);
      cond[i] <= 1'b0;
      tick(2);
      check(8'(interrupt_pin_oe_n), 8'h01);
    end
    cond[0] <= 1'b1;
    tick(2);
    wr(mmst_pkg::REG_MASK, {4'h0, rnd[3:1], 1'b1});
    tick(2);
    check(8'(interrupt_pin_oe_n), 8'h01);
    rd(mmst_pkg::REG_MASK, {4'h0, rnd[3:1], 1'b1}, 8'h0f);
    wr(mmst_pkg::REG_MASK, 8'h00);
    tick(2);
    check(8'(interrupt_pin_oe_n), 8'h00);
    cond[0] <= 1'b0;
    rd(mmst_pkg::REG_FLAGS, 8'h01, 8'hff);
    tick(2);
    check(8'(interrupt_pin_oe_n), 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr(mmst_pkg::REG_CONTROL, 8'(8'h01 << i));
      tick(3);
      check({6'h0, low_power_mode, full_function}, 8'h02);
      wr(mmst_pkg::REG_CONTROL, 8'h00);
      wait_for(1, 1'b1, WAKE + 4);
      check(8'(full_function), 8'h01);
    end
    host.set_low_power(1'b1);
    tick(3);
    check(8'(low_power_mode), 8'h01);
    host.set_low_power(1'b0);
    wait_for(1, 1'b1, WAKE + 4);
    check(8'(full_function), 8'h01);
    wr(mmst_pkg::REG_CONTROL, 8'h04);
    tick(1);
    host.set_low_power(1'b1);
    tick(3);
    check({6'h0, transmit_disable, low_power_mode}, 8'h02);
    host.set_low_power(1'b0);
    wr(mmst_pkg::REG_CONTROL, 8'h08);
    tick(2);
    cond[0] <= 1'b1;
    tick(3);
    check(8'(interrupt_pin_oe_n), 8'h00);
    cond[0] <= 1'b0;
    tick(3);
    check(8'(interrupt_pin_oe_n), 8'h01);
    wr(mmst_pkg::REG_CONTROL, 8'h00);
    rd(mmst_pkg::REG_FLAGS, 8'h00, 8'hfe);
    tick(2);
    host.pulse_reset(50);
    tick(3);
    check(8'(bus_ready), 8'h01);
    host.pulse_reset(mmst_pkg::RESET_MIN_CYCLES + 8);
    tick(1);
    check(8'(management_init_state), 8'h01);
    wait_for(0, 1'b1, INIT + 4);
    check(8'(bus_ready), 8'h01);
    tick(2);
    rd(mmst_pkg::REG_FLAGS, 8'h04, 8'hff);
    wr(mmst_pkg::REG_MASK, 8'h0f);
    tick(3);
    reset <= 1'b1;
    tick(3);
    check(8'(bus_ready), 8'h00);
    reset <= 1'b0;
    wait_for(0, 1'b1, INIT + 4);
    tick(2);
    check(8'(interrupt_pin_oe_n), 8'h00);
    rd(mmst_pkg::REG_MASK, 8'h00, 8'hff);
    tick(2);
    results();
  end
endmodule
